// ---- bench/bus_ctrl_props.sv ----
// Purpose: bus, pin and interrupt checks of the control block
// Assumes: pins follow register writes one cycle late
// Notes: helper copies track writes taken on the bus
`timescale 1ns/1ps
`default_nettype none
module bus_ctrl_props
   import bus_ctrl_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire line_pair_type line_in,
   input wire line_pair_type line_out,
   input wire line_pair_type line_oe_n,
   input wire logic irq_request
);
   logic wr;
   logic en_q;
   logic [3:0] ctl_q;
   logic [3:0] pt_q;
   logic [8:0] cfg;
   assign wr = avs_write && !avs_waitrequest && avs_byteenable[0];
   assign cfg = {en_q, ctl_q, pt_q};
   // one block: the copies share a single write strobe
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         {en_q, ctl_q, pt_q} <= 9'h000;
      else if (wr && avs_address == OFS_IF_CONTROL_0)
         en_q <= avs_writedata[0] & ~avs_writedata[1];
      else if (wr && avs_address == OFS_BUS_CONTROL_1)
         ctl_q <= avs_writedata[3:0];
      else if (wr && avs_address == OFS_PORT_CONTROL)
         pt_q <= avs_writedata[3:0];
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   sequence s_stop;
      $rose(line_in.sda) && line_in.scl && $past(line_in.scl);
   endsequence
   property p_stop;
      s_stop ##0 (en_q && ctl_q[0]) |-> ##[1:3] irq_request;
   endproperty
   a_stop: assert property (p_stop)
      else $error("stop gave no interrupt");
   property p_wait;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_wait: assert property (p_wait)
      else $error("access not answered");
   property p_rdhi;
      avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0;
   endproperty
   a_rdhi: assert property (p_rdhi)
      else $error("upper read bytes set");
   property p_pulse;
      irq_request |=> !irq_request;
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("interrupt longer than a cycle");
   property p_scl;
      $stable(cfg) && en_q && ctl_q[3]
         |-> line_out.scl == pt_q[1] && !line_oe_n.scl;
   endproperty
   a_scl: assert property (p_scl)
      else $error("scl override wrong");
   property p_sda;
      $stable(cfg) && en_q && ctl_q[2]
         |-> line_out.sda == pt_q[0] && !line_oe_n.sda;
   endproperty
   a_sda: assert property (p_sda)
      else $error("sda override wrong");
   property p_od;
      $stable(cfg) && en_q && ctl_q[3:2] == 2'h0 |-> line_out == 2'h0;
   endproperty
   a_od: assert property (p_od)
      else $error("open drain drives high");
   property p_dis;
      $stable(cfg) && !en_q |-> line_oe_n == ~pt_q[3:2];
   endproperty
   a_dis: assert property (p_dis)
      else $error("disabled pin direction wrong");
endmodule // bus_ctrl_props
bind i2c_rx_irq_pin_clock_timeout_ctrl bus_ctrl_props u_props (.*);
`default_nettype wire

// ---- bench/far_end.sv ----
// Purpose: far side master framing bytes on the two lines
// Assumes: both lines open drain with pull-ups
// Notes: waits while the block stretches the clock low
`timescale 1ns/1ps
`default_nettype none
module far_end
   import bus_ctrl_pkg::*;
(
   input wire logic clk,
   input wire line_pair_type dut_out,
   input wire line_pair_type dut_oe_n,
   output wire line_pair_type bus
);
   logic m_scl = 1'b1;
   logic m_sda = 1'b1;
   // pulled up: a released line reads high, never the last value
   assign bus.scl = m_scl & (dut_oe_n.scl | dut_out.scl);
   assign bus.sda = m_sda & (dut_oe_n.sda | dut_out.sda);
   task automatic half;
      repeat (10) @(posedge clk);
   endtask
   // waits out a stretch; the bench cycle ceiling ends a hang
   task automatic rise;
      m_scl <= 1'b1;
      while (bus.scl !== 1'b1)
         @(posedge clk);
      half;
   endtask
   task automatic bit_out(input logic b);
      m_scl <= 1'b0;
      half;
      m_sda <= b;
      half;
      rise;
   endtask
   task automatic send_byte(input logic [7:0] d);
      for (int i = 7; i >= 0; i--)
         bit_out(d[i]);
      bit_out(1'b1);
      m_scl <= 1'b0;
      half;
   endtask
   task automatic start;
      m_sda <= 1'b0;
      half;
   endtask
   task automatic stop;
      bit_out(1'b0);
      m_sda <= 1'b1;
      half;
   endtask
endmodule // far_end
`default_nettype wire

// ---- bench/testbench.sv ----
// Purpose: register level test of the control block
// Assumes: lines sampled on core_clk
// Notes: timeout lengths cut to 64 and 16 ticks
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import bus_ctrl_pkg::*;
   localparam int TS = 16;
   localparam logic [4:0] C1 = OFS_BUS_CONTROL_1;
   localparam logic [4:0] C2 = OFS_BUS_CONTROL_2;
   localparam logic [4:0] IC = OFS_IF_CONTROL_0;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic irq_request;
   line_pair_type line_in;
   line_pair_type line_out;
   line_pair_type line_oe_n;
   logic [7:0] rd;
   int n_fail = 0;
   int tests_run = 0;
   int n_irq = 0;
   int cyc = 0;
   i2c_rx_irq_pin_clock_timeout_ctrl #(.TIMEOUT_LONG_CYCLES(64),
      .TIMEOUT_SHORT_CYCLES(TS)) u_i2c_rx_irq_pin_clock_timeout_ctrl (.*);
   far_end u_far_end (.clk(core_clk), .dut_out(line_out),
      .dut_oe_n(line_oe_n), .bus(line_in));
   initial
   begin
      forever #2.5 core_clk = ~core_clk;
   end
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // pulses last one cycle, so count them on every edge
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      if (irq_request === 1'b1)
         n_irq <= n_irq + 1;
      if (cyc == 20000)
      begin
         n_fail = n_fail + 1;
         summarize;
      end
   end
   task automatic acc(input logic [4:0] a, input logic w,
      input logic [7:0] d);
      @(posedge core_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= {24'h0, d};
      do
         @(posedge core_clk);
      while (avs_waitrequest !== 1'b0);
      rd = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      acc(a, 1'b1, d);
   endtask
   task automatic chk(input logic [7:0] g, e, m);
      tests_run++;
      if ((g & m) !== (e & m))
      begin
         n_fail++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic rc(input logic [4:0] a, input logic [7:0] e, m);
      acc(a, 1'b0, 8'h00);
      chk(rd, e, m);
   endtask
   initial
   begin
      repeat (6) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      rc(C1, 8'h30, 8'hff);
      rc(C2, 8'h00, 8'hff);
      rc(5'h1c, 8'h00, 8'hff);
      wr(OFS_ACK_CONTROL, 8'h02);
      wr(C1, 8'h03);
      rc(C1, 8'h01, 8'hcf);
      wr(OFS_PORT_CONTROL, 8'h03);
      wr(IC, 8'h01);
      wr(C1, 8'h0c);
      u_far_end.start;
      rc(OFS_PORT_CONTROL, 8'h02, 8'h0f);
      wr(C1, 8'h00);
      u_far_end.stop;
      chk(n_irq[7:0], 8'h00, 8'hff);
      rc(C2, 8'h00, 8'hff);
      wr(IC, 8'h00);
      wr(OFS_ACK_CONTROL, 8'h02);
      wr(C1, 8'h03);
      wr(IC, 8'h01);
      u_far_end.start;
      u_far_end.send_byte(8'ha0);
      chk(n_irq[7:0], 8'h01, 8'hff);
      rc(C1, 8'h01, 8'hcf);
      wr(OFS_DATA_SHIFT, 8'h00);
      rc(C1, 8'h03, 8'hcf);
      fork
         u_far_end.send_byte(8'h5a);
         begin
            while (n_irq < 2)
               @(posedge core_clk);
            rc(OFS_STATUS_0, 8'h04, 8'h06);
            rc(C1, 8'h03, 8'hff);
            wr(OFS_ACK_CONTROL, 8'h02);
         end
      join
      chk(n_irq[7:0], 8'h03, 8'hff);
      rc(C1, 8'h01, 8'hcf);
      rc(OFS_DATA_SHIFT, 8'h5a, 8'hff);
      wr(OFS_DATA_SHIFT, 8'h00);
      u_far_end.stop;
      chk(n_irq[7:0], 8'h04, 8'hff);
      rc(C2, 8'h80, 8'hff);
      wr(C2, 8'h00);
      rc(C2, 8'h00, 8'hff);
      wr(IC, 8'h00);
      for (int k = 0; k < 2; k++)
      begin
         wr(C1, k ? 8'h40 : 8'h00);
         wr(C2, 8'h05);
         wr(IC, 8'h01);
         u_far_end.start;
         repeat (TS * (2 + 2 * k) - 20) @(posedge core_clk);
         rc(C2, 8'h05, 8'hff);
         repeat (20) @(posedge core_clk);
         rc(C2, 8'h07, 8'hff);
         chk(n_irq[7:0], 8'(5 + k), 8'hff);
         wr(IC, 8'h00);
         rc(C2, 8'h05, 8'hff);
         u_far_end.stop;
      end
      summarize;
   end
endmodule // testbench
`default_nettype wire

// ---- verilog/bus_ctrl_pkg.sv ----
// Purpose: shared constants and types of the bus control block
// Assumes: 32-bit register bus, 8-bit registers in the low lane
// Notes: offsets are byte addresses of aligned words
package bus_ctrl_pkg;

   // ***************************************************************
   // register offsets
   // ***************************************************************
   localparam logic [4:0] OFS_BUS_CONTROL_1 = 5'h00;
   localparam logic [4:0] OFS_BUS_CONTROL_2 = 5'h04;
   localparam logic [4:0] OFS_IF_CONTROL_0 = 5'h08;
   localparam logic [4:0] OFS_ACK_CONTROL = 5'h0c;
   localparam logic [4:0] OFS_DATA_SHIFT = 5'h10;
   localparam logic [4:0] OFS_STATUS_0 = 5'h14;
   localparam logic [4:0] OFS_PORT_CONTROL = 5'h18;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] SHIFT_RESET = 8'hff;

   // ***************************************************************
   // field positions
   // ***************************************************************
   localparam int BC1_STOP_IRQ_EN = 0;
   localparam int BC1_RX_TIMING = 1;
   localparam int BC1_SDA_OVR = 2;
   localparam int BC1_SCL_OVR = 3;
   localparam int BC1_DIV_LO = 6;
   localparam int BC1_DIV_LO_TOP = 7;
   localparam int BC2_TO_EN = 0;
   localparam int BC2_TO_LEN = 2;
   localparam int BC2_DIV_HI = 3;
   localparam int BC2_DIV_HI_TOP = 5;
   localparam int BC2_SPARE = 6;
   localparam int BC2_STOP_FLAG = 7;
   localparam int IC0_ENABLE = 0;
   localparam int IC0_RESET = 1;
   localparam int IC0_TRANSMIT = 2;
   localparam int ACK_LEVEL = 0;
   localparam int ACK_CLK_EN = 1;
   localparam int PORT_BIT = 0;
   localparam int PORT_DIR = 2;
   localparam int PIN_SDA = 0;
   localparam int PIN_SCL = 1;

   // ***************************************************************
   // clock divider codes and periods in half source cycles
   // ***************************************************************
   localparam logic [4:0] DIV_CODE_2 = 5'h00;
   localparam logic [4:0] DIV_CODE_4 = 5'h01;
   localparam logic [4:0] DIV_CODE_8 = 5'h02;
   localparam logic [2:0] DIV_GRP_2P5 = 3'h1;
   localparam logic [2:0] DIV_GRP_3 = 3'h2;
   localparam logic [2:0] DIV_GRP_5 = 3'h3;
   localparam logic [2:0] DIV_GRP_6 = 3'h4;
   localparam logic [4:0] HALF_2 = 5'h04;
   localparam logic [4:0] HALF_4 = 5'h08;
   localparam logic [4:0] HALF_8 = 5'h10;
   localparam logic [4:0] HALF_2P5 = 5'h05;
   localparam logic [4:0] HALF_3 = 5'h06;
   localparam logic [4:0] HALF_5 = 5'h0a;
   localparam logic [4:0] HALF_6 = 5'h0c;
   localparam logic [4:0] HALF_STEP = 5'h02;

   // ***************************************************************
   // byte framing and timeout
   // ***************************************************************
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;
   localparam int TIMEOUT_WIDTH = 17;

   typedef struct packed {
      logic scl;
      logic sda;
   } line_pair_type;

endpackage

// ---- verilog/clock_divider.sv ----
// Purpose: interface clock tick from the source clock
// Assumes: select only changes while run is low
// Notes: fractional ratios alternate short and long periods
`timescale 1ns/1ps
`default_nettype none
module clock_divider
   import bus_ctrl_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic [4:0] select,
   output logic tick
);

   logic [4:0] half_period;
   logic [4:0] acc_q;
   logic [4:0] acc_d;
   logic tick_q;

   // ***************************************************************
   // ratio decode
   // ***************************************************************
   always_comb
   begin
      half_period = '0;
      if (select == DIV_CODE_2)
         half_period = HALF_2;
      else if (select == DIV_CODE_4)
         half_period = HALF_4;
      else if (select == DIV_CODE_8)
         half_period = HALF_8;
      else if (select[4:2] == DIV_GRP_2P5)
         half_period = HALF_2P5;
      else if (select[4:2] == DIV_GRP_3)
         half_period = HALF_3;
      else if (select[4:2] == DIV_GRP_5)
         half_period = HALF_5;
      else if (select[4:2] == DIV_GRP_6)
         half_period = HALF_6;
   end

   // prohibited codes leave half_period at zero and stop the tick
   assign acc_d = acc_q + HALF_STEP;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         acc_q <= '0;
         tick_q <= 1'b0;
      end
      else if (!run || half_period == '0)
      begin
         acc_q <= '0;
         tick_q <= 1'b0;
      end
      else if (acc_d >= half_period)
      begin
         acc_q <= acc_d - half_period;
         tick_q <= 1'b1;
      end
      else
      begin
         acc_q <= acc_d;
         tick_q <= 1'b0;
      end
   end

   assign tick = tick_q;

endmodule // clock_divider
`default_nettype wire

// ---- verilog/i2c_rx_irq_pin_clock_timeout_ctrl.sv ----
// Purpose: receive interrupt timing, pin override, divider, timeout
// Assumes: bus lines sampled synchronously to core_clk
// Notes: start, stop and bit edges are seen from the line levels
`timescale 1ns/1ps
`default_nettype none
module i2c_rx_irq_pin_clock_timeout_ctrl
   import bus_ctrl_pkg::*;
#(
   parameter int unsigned TIMEOUT_LONG_CYCLES = 65536,
   parameter int unsigned TIMEOUT_SHORT_CYCLES = 16384
)
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire line_pair_type line_in,
   output line_pair_type line_out,
   output line_pair_type line_oe_n,
   output logic irq_request
);

   // ***************************************************************
   // reset release
   // ***************************************************************
   logic rst_meta_q;
   logic rst_n;

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rst_meta_q <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_n <= rst_meta_q;
      end
   end

   // ***************************************************************
   // register bus slave
   // ***************************************************************
   logic ack_q;
   logic [7:0] readdata_q;
   logic [7:0] rd_mux;
   logic wr_fire;
   logic wr_bc1, wr_bc2, wr_ic0, wr_ack, wr_data, wr_port;
   logic [7:0] wdata;
   logic [7:0] bus_control_1_q;
   logic [7:0] bus_control_2_q;
   logic [7:0] interface_control_0_q;
   logic [7:0] ack_control_register_q;
   logic [7:0] port_control_q;
   logic [7:0] rx_byte_q;
   logic stop_detect_flag_q;
   logic timeout_flag_q;
   logic hold_q;
   logic pending_q;
   logic bus_busy_flag_q;
   logic addr_phase_q;
   logic scl_int, sda_int;
   logic [1:0] port_read;

   // one wait cycle on every access, answer on the second edge
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
   assign wr_fire = avs_write & ack_q & avs_byteenable[0];
   assign wdata = avs_writedata[7:0];
   assign wr_bc1 = wr_fire && avs_address == OFS_BUS_CONTROL_1;
   assign wr_bc2 = wr_fire && avs_address == OFS_BUS_CONTROL_2;
   assign wr_ic0 = wr_fire && avs_address == OFS_IF_CONTROL_0;
   assign wr_ack = wr_fire && avs_address == OFS_ACK_CONTROL;
   assign wr_data = wr_fire && avs_address == OFS_DATA_SHIFT;
   assign wr_port = wr_fire && avs_address == OFS_PORT_CONTROL;

   always_comb
   begin
      rd_mux = REG_RESET;
      unique case (avs_address)
         OFS_BUS_CONTROL_1:
            rd_mux = {bus_control_1_q[BC1_DIV_LO_TOP:BC1_DIV_LO],
                      scl_int, sda_int,
                      bus_control_1_q[BC1_SCL_OVR:BC1_SDA_OVR],
                      hold_q,
                      bus_control_1_q[BC1_STOP_IRQ_EN]};
         OFS_BUS_CONTROL_2:
            rd_mux = {stop_detect_flag_q,
                      bus_control_2_q[BC2_SPARE:BC2_TO_LEN],
                      timeout_flag_q & bus_control_2_q[BC2_TO_EN],
                      bus_control_2_q[BC2_TO_EN]};
         OFS_IF_CONTROL_0: rd_mux = interface_control_0_q;
         OFS_ACK_CONTROL: rd_mux = ack_control_register_q;
         OFS_DATA_SHIFT: rd_mux = rx_byte_q;
         OFS_STATUS_0:
            rd_mux = {4'h0, addr_phase_q, hold_q, pending_q,
                      bus_busy_flag_q};
         OFS_PORT_CONTROL:
            rd_mux = {port_control_q[7:2], port_read};
         default: rd_mux = REG_RESET;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ack_q <= 1'b0;
         readdata_q <= REG_RESET;
      end
      else
      begin
         ack_q <= (avs_read | avs_write) & ~ack_q;
         if (avs_read && !ack_q)
            readdata_q <= rd_mux;
      end
   end

   assign avs_readdata = {24'h0, readdata_q};

   // ***************************************************************
   // control registers
   // ***************************************************************
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bus_control_1_q <= REG_RESET;
         bus_control_2_q <= REG_RESET;
         interface_control_0_q <= REG_RESET;
         ack_control_register_q <= REG_RESET;
         port_control_q <= REG_RESET;
      end
      else
      begin
         // monitor bits are never stored; reads rebuild them
         if (wr_bc1)
            bus_control_1_q <= wdata & 8'hcf;
         if (wr_bc2)
            bus_control_2_q <= wdata & 8'h7d;
         if (wr_ic0)
            interface_control_0_q <= wdata & 8'h07;
         if (wr_ack)
            ack_control_register_q <= wdata & 8'h03;
         if (wr_port)
            port_control_q <= wdata & 8'h0f;
      end
   end

   logic en_run;
   logic ack_clk_en;
   logic rx_timing_sel;
   logic transmit_mode;
   logic rx_data_mode;

   assign en_run = interface_control_0_q[IC0_ENABLE]
                   & ~interface_control_0_q[IC0_RESET];
   assign ack_clk_en = ack_control_register_q[ACK_CLK_EN];
   assign rx_timing_sel = bus_control_1_q[BC1_RX_TIMING];
   assign transmit_mode = interface_control_0_q[IC0_TRANSMIT];
   assign rx_data_mode = ~transmit_mode & ~addr_phase_q;

   // ***************************************************************
   // line edges, framing and byte engine
   // ***************************************************************
   logic scl_prev_q, sda_prev_q;
   logic pulse_seen_q;
   logic scl_fall, scl_rise, start_seen, stop_seen;
   logic [3:0] bit_cnt_q;
   logic ev8, ev9;
   logic irq8, irq_noack, irq9, stop_set, timeout_set;
   logic wait_q, wait8_q;
   logic resume;
   logic [7:0] tx_shift_q;
   logic [7:0] rx_shift_q;

   // the fall that ends a start condition is no clock pulse
   assign scl_fall = scl_prev_q & ~line_in.scl & pulse_seen_q;
   assign scl_rise = ~scl_prev_q & line_in.scl;
   assign start_seen = en_run & line_in.scl & scl_prev_q
                       & sda_prev_q & ~line_in.sda;
   assign stop_seen = en_run & line_in.scl & scl_prev_q
                      & ~sda_prev_q & line_in.sda;
   assign ev8 = bus_busy_flag_q & scl_fall & (bit_cnt_q == BIT_LAST);
   assign ev9 = bus_busy_flag_q & scl_fall & (bit_cnt_q == BIT_ACK);
   assign irq8 = ev8 & ack_clk_en & rx_timing_sel
                 & rx_data_mode;
   assign irq_noack = ev8 & ~ack_clk_en;
   assign irq9 = ev9;
   assign stop_set = stop_seen
                     & bus_control_1_q[BC1_STOP_IRQ_EN];
   // the wait kind picks which write lets the byte go on
   assign resume = wait_q & (wait8_q ? wr_ack : wr_data);

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end
      else
      begin
         scl_prev_q <= line_in.scl;
         sda_prev_q <= line_in.sda;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         pulse_seen_q <= 1'b0;
      else if (!en_run || start_seen)
         pulse_seen_q <= 1'b0;
      else if (scl_rise)
         pulse_seen_q <= 1'b1;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bus_busy_flag_q <= 1'b0;
         addr_phase_q <= 1'b0;
         bit_cnt_q <= '0;
      end
      else if (!en_run || stop_seen)
      begin
         bus_busy_flag_q <= 1'b0;
         addr_phase_q <= 1'b0;
         bit_cnt_q <= '0;
      end
      else if (start_seen)
      begin
         bus_busy_flag_q <= 1'b1;
         addr_phase_q <= 1'b1;
         bit_cnt_q <= '0;
      end
      else if (ev9 || (ev8 && !ack_clk_en))
      begin
         addr_phase_q <= 1'b0;
         bit_cnt_q <= '0;
      end
      else if (bus_busy_flag_q && scl_fall)
         bit_cnt_q <= bit_cnt_q + 4'h1;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_shift_q <= SHIFT_RESET;
         rx_shift_q <= REG_RESET;
         rx_byte_q <= REG_RESET;
      end
      else
      begin
         if (wr_data)
            tx_shift_q <= wdata;
         else if (transmit_mode && scl_fall && bit_cnt_q < BIT_ACK)
            tx_shift_q <= {tx_shift_q[6:0], 1'b1};
         if (scl_rise && bit_cnt_q < BIT_ACK)
            rx_shift_q <= {rx_shift_q[6:0], line_in.sda};
         if (ev8)
            rx_byte_q <= rx_shift_q;
      end
   end

   // ***************************************************************
   // hold flag, pending flag and clock stretch
   // ***************************************************************
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         hold_q <= 1'b0;
      else if (!en_run || !rx_data_mode)
         hold_q <= 1'b0;
      else if (rx_timing_sel && wr_data)
         hold_q <= 1'b1;
      else if (rx_timing_sel && wr_ack)
         hold_q <= 1'b0;
   end

   // a new request wins over a resume write in the same cycle
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pending_q <= 1'b1;
         wait_q <= 1'b0;
         wait8_q <= 1'b0;
      end
      else if (!en_run)
      begin
         pending_q <= 1'b1;
         wait_q <= 1'b0;
         wait8_q <= 1'b0;
      end
      else if (irq8 || irq9 || irq_noack)
      begin
         pending_q <= 1'b0;
         wait_q <= 1'b1;
         wait8_q <= irq8;
      end
      else if (resume)
      begin
         pending_q <= 1'b1;
         wait_q <= 1'b0;
         wait8_q <= 1'b0;
      end
   end

   // scl is held low while software owes an answer
   assign scl_int = ~wait_q;
   assign sda_int = transmit_mode
                    ? (bit_cnt_q < BIT_ACK ? tx_shift_q[7] : 1'b1)
                    : (bit_cnt_q == BIT_ACK && ack_clk_en
                       ? ack_control_register_q[ACK_LEVEL] : 1'b1);

   // ***************************************************************
   // stop flag and timeout
   // ***************************************************************
   logic tick;
   logic [TIMEOUT_WIDTH-1:0] to_cnt_q;
   logic [TIMEOUT_WIDTH-1:0] to_limit;
   logic to_run;

   clock_divider u_clock_divider (
      .clk(core_clk),
      .rst_n(rst_n),
      .run(en_run),
      .select({bus_control_2_q[BC2_DIV_HI_TOP:BC2_DIV_HI],
               bus_control_1_q[BC1_DIV_LO_TOP:BC1_DIV_LO]}),
      .tick(tick)
   );

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         stop_detect_flag_q <= 1'b0;
      else if (stop_set)
         stop_detect_flag_q <= 1'b1;
      else if (wr_bc2 && !wdata[BC2_STOP_FLAG])
         stop_detect_flag_q <= 1'b0;
   end

   assign to_limit = bus_control_2_q[BC2_TO_LEN]
                     ? TIMEOUT_WIDTH'(TIMEOUT_SHORT_CYCLES - 1)
                     : TIMEOUT_WIDTH'(TIMEOUT_LONG_CYCLES - 1);
   assign to_run = bus_control_2_q[BC2_TO_EN] & bus_busy_flag_q
                   & line_in.scl;
   assign timeout_set = en_run & to_run & tick & ~timeout_flag_q
                        & (to_cnt_q == to_limit);

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         to_cnt_q <= '0;
         timeout_flag_q <= 1'b0;
      end
      else if (!en_run)
      begin
         to_cnt_q <= '0;
         timeout_flag_q <= 1'b0;
      end
      else if (!to_run)
         to_cnt_q <= '0;
      else if (timeout_set)
         timeout_flag_q <= 1'b1;
      else if (tick && !timeout_flag_q)
         to_cnt_q <= to_cnt_q + 1'b1;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         irq_request <= 1'b0;
      else
         irq_request <= irq8 | irq_noack | irq9 | stop_set
                        | timeout_set;
   end

   // ***************************************************************
   // pin functions
   // ***************************************************************
   logic [1:0] pin_in, pin_ovr, pin_int, pin_out_q, pin_oe_n_q;

   assign pin_in = {line_in.scl, line_in.sda};
   assign pin_ovr = {bus_control_1_q[BC1_SCL_OVR],
                     bus_control_1_q[BC1_SDA_OVR]};
   assign pin_int = {scl_int, sda_int};

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_pin
         assign port_read[gi] = port_control_q[PORT_DIR + gi]
                                ? port_control_q[PORT_BIT + gi]
                                : pin_in[gi];
         always_ff @(posedge core_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               pin_out_q[gi] <= 1'b1;
               pin_oe_n_q[gi] <= 1'b1;
            end
            else if (!interface_control_0_q[IC0_ENABLE])
            begin
               pin_out_q[gi] <= port_control_q[PORT_BIT + gi];
               pin_oe_n_q[gi] <= ~port_control_q[PORT_DIR + gi];
            end
            else if (pin_ovr[gi])
            begin
               pin_out_q[gi] <= port_control_q[PORT_BIT + gi];
               pin_oe_n_q[gi] <= 1'b0;
            end
            else
            begin
               pin_out_q[gi] <= 1'b0;
               pin_oe_n_q[gi] <= pin_int[gi];
            end
         end
      end
   endgenerate

   assign line_out.scl = pin_out_q[PIN_SCL];
   assign line_out.sda = pin_out_q[PIN_SDA];
   assign line_oe_n.scl = pin_oe_n_q[PIN_SCL];
   assign line_oe_n.sda = pin_oe_n_q[PIN_SDA];

endmodule // i2c_rx_irq_pin_clock_timeout_ctrl
`default_nettype wire
